// ===== include/bfc_pkg.sv
package bfc_pkg;

  // ---------------------------------------------------------------------------
  // Register map (Avalon-MM byte addresses, one word each)
  // ---------------------------------------------------------------------------
  localparam logic [4:0] REG_CTRL   = 5'h00;
  localparam logic [4:0] REG_ADDR   = 5'h04;
  localparam logic [4:0] REG_WDATA  = 5'h08;
  localparam logic [4:0] REG_RDATA  = 5'h0c;
  localparam logic [4:0] REG_STATUS = 5'h10;

  // CTRL fields (write starts a command)
  localparam int CTRL_OP_LSB    = 0;
  localparam int CTRL_WIDE_BIT  = 4;
  localparam int CTRL_ACCEL_BIT = 5;

  // Operation codes
  localparam logic [1:0] OP_NONE  = 2'h0;
  localparam logic [1:0] OP_READ  = 2'h1;
  localparam logic [1:0] OP_WRITE = 2'h2;
  localparam logic [1:0] OP_RESET = 2'h3;

  // STATUS fields
  localparam int ST_BUSY_BIT  = 0;
  localparam int ST_READY_BIT = 1;
  localparam int ST_BANK_LSB  = 2;
  localparam int ST_ACCEL_BIT = 4;

  // Bank decode patterns of the three top address bits
  localparam logic [2:0] BANK_ONE_PAT  = 3'h0;
  localparam logic [2:0] BANK_FOUR_PAT = 3'h7;
  localparam logic [2:0] BANK_TWO_TOP  = 3'h3;

  // ---------------------------------------------------------------------------
  // Timing (ns) and derived cycle counts at 200 MHz
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS      = 5;
  localparam int ACCESS_TIME_NS     = 70;
  localparam int CE_ACCESS_TIME_NS  = 70;
  localparam int WRITE_PULSE_NS     = 35;
  localparam int WRITE_HOLD_NS      = 20;
  localparam int RESET_PULSE_NS     = 500;
  localparam int RESET_RECOVERY_NS  = 50;
  localparam int ACCESS_CYC    = (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CE_ACCESS_CYC = (CE_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_PULSE_CYC  = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_HOLD_CYC   = (WRITE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_PULSE_CYC = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_REC_CYC   = (RESET_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int ADDR_W = 22;
  localparam int DATA_W = 32;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RD_WAIT,
    ST_WR_PULSE,
    ST_WR_HOLD,
    ST_RST_PULSE,
    ST_RST_REC
  } bfc_state_e;

  // Flash pin control group
  typedef struct packed {
    logic chip_sel_n;
    logic out_en_n;
    logic write_n;
    logic reset_n;
    logic wide_sel;
    logic accel_program_pin;
  } bfc_pins_s;

endpackage

// ===== rtl/bfc_host.sv
// Local design decisions: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
module bfc_host
  import bfc_pkg::*;
#(
  parameter int ACC_CYC   = ACCESS_CYC,
  parameter int CE_CYC    = CE_ACCESS_CYC,
  parameter int WP_CYC    = WR_PULSE_CYC,
  parameter int WH_CYC    = WR_HOLD_CYC,
  parameter int RP_CYC    = RST_PULSE_CYC,
  parameter int RH_CYC    = RST_REC_CYC
) (
  input  wire logic              clock,
  input  wire logic              resetn,
  input  wire logic [4:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  output bfc_pins_s              flash_ctl,
  output logic      [ADDR_W-1:0] flash_addr,
  output logic      [DATA_W-1:0] flash_dq_out,
  output logic                   flash_dq_oe_n,
  input  wire logic [DATA_W-1:0] flash_dq_in,
  input  wire logic              ready_busy_out
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  bfc_state_e        state_q;
  logic [15:0]       cnt_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [DATA_W-1:0] rdata_q;
  logic              wide_q;
  logic              accel_q;
  logic              was_idle_q;
  logic              rdy_q;
  logic [1:0]        bank_q;
  logic              ack_q;

  wire cmd_go   = avs_write && !ack_q && avs_address == REG_CTRL && state_q == ST_IDLE;
  wire [1:0] op = avs_writedata[CTRL_OP_LSB +: 2];

  // ---------------------------------------------------------------------------
  // Bank decode
  // ---------------------------------------------------------------------------
  function automatic logic [1:0] bank_of(input logic [2:0] top);
    if (top == BANK_ONE_PAT)       bank_of = 2'h0;
    else if (top == BANK_FOUR_PAT) bank_of = 2'h3;
    else if (top <= BANK_TWO_TOP)  bank_of = 2'h1;
    else                           bank_of = 2'h2;
  endfunction

  // ---------------------------------------------------------------------------
  // Avalon slave: one wait cycle, then acknowledge
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ack_q        <= 1'b0;
      avs_readdata <= 32'h0;
    end else begin
      ack_q <= (avs_read || avs_write) && !ack_q;
      if (avs_read && !ack_q) begin
        case (avs_address)
          REG_CTRL:   avs_readdata <= {26'h0, accel_q, wide_q, 4'h0};
          REG_ADDR:   avs_readdata <= {10'h0, addr_q};
          REG_WDATA:  avs_readdata <= wdata_q;
          REG_RDATA:  avs_readdata <= rdata_q;
          REG_STATUS: avs_readdata <= {27'h0, accel_q, bank_q, rdy_q, state_q != ST_IDLE};
          default:    avs_readdata <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) avs_waitrequest <= 1'b1;
    else         avs_waitrequest <= !((avs_read || avs_write) && !ack_q);
  end

  // ---------------------------------------------------------------------------
  // Software-set registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      addr_q  <= '0;
      wdata_q <= '0;
      wide_q  <= 1'b1;
      accel_q <= 1'b0;
      bank_q  <= 2'h0;
    end else if (avs_write && !ack_q && state_q == ST_IDLE) begin
      // Address and data survive a flash reset so software can reissue the cut operation
      if (avs_address == REG_ADDR) begin
        addr_q <= avs_writedata[ADDR_W-1:0];
        bank_q <= bank_of(avs_writedata[ADDR_W-1 -: 3]);
      end
      if (avs_address == REG_WDATA) wdata_q <= avs_writedata;
      if (avs_address == REG_CTRL) begin
        wide_q  <= avs_writedata[CTRL_WIDE_BIT];
        accel_q <= avs_writedata[CTRL_ACCEL_BIT];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Bus cycle sequencer
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_q    <= ST_IDLE;
      cnt_q      <= 16'h0;
      rdata_q    <= '0;
      was_idle_q <= 1'b1;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (cmd_go) begin
            case (op)
              OP_READ: begin
                state_q <= ST_RD_WAIT;
                cnt_q   <= 16'((ACC_CYC > CE_CYC) ? ACC_CYC : CE_CYC);
              end
              OP_WRITE: begin
                state_q <= ST_WR_PULSE;
                cnt_q   <= 16'(WP_CYC);
              end
              OP_RESET: begin
                state_q <= ST_RST_PULSE;
                cnt_q   <= 16'(RP_CYC);
              end
              default: state_q <= ST_IDLE;
            endcase
          end
        end
        ST_RD_WAIT: begin
          if (cnt_q <= 16'h1) begin
            rdata_q <= wide_q ? flash_dq_in : {16'h0, flash_dq_in[15:0]};
            state_q <= ST_IDLE;
          end else cnt_q <= cnt_q - 16'h1;
        end
        ST_WR_PULSE: begin
          if (cnt_q <= 16'h1) begin
            state_q <= ST_WR_HOLD;
            cnt_q   <= 16'(WH_CYC);
          end else cnt_q <= cnt_q - 16'h1;
        end
        ST_WR_HOLD: begin
          if (cnt_q <= 16'h1) state_q <= ST_IDLE;
          else cnt_q <= cnt_q - 16'h1;
        end
        ST_RST_PULSE: begin
          was_idle_q <= ready_busy_out;
          if (cnt_q <= 16'h1) begin
            state_q <= ST_RST_REC;
            cnt_q   <= 16'(RH_CYC);
          end else cnt_q <= cnt_q - 16'h1;
        end
        ST_RST_REC: begin
          // Wait out recovery and, if busy, the device's internal reset
          if (cnt_q <= 16'h1) begin
            if (ready_busy_out) state_q <= ST_IDLE;
          end else cnt_q <= cnt_q - 16'h1;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) rdy_q <= 1'b0;
    else         rdy_q <= ready_busy_out;
  end

  // ---------------------------------------------------------------------------
  // Pin drivers (registered)
  // ---------------------------------------------------------------------------
  bfc_state_e nxt;
  always_comb begin
    nxt = state_q;
    if (state_q == ST_IDLE && cmd_go) begin
      case (op)
        OP_READ:  nxt = ST_RD_WAIT;
        OP_WRITE: nxt = ST_WR_PULSE;
        OP_RESET: nxt = ST_RST_PULSE;
        default:  nxt = ST_IDLE;
      endcase
    end else if (state_q == ST_WR_PULSE && cnt_q <= 16'h1) nxt = ST_WR_HOLD;
    else if (state_q == ST_RST_PULSE && cnt_q <= 16'h1) nxt = ST_RST_REC;
    else if ((state_q == ST_RD_WAIT || state_q == ST_WR_HOLD) && cnt_q <= 16'h1) nxt = ST_IDLE;
    else if (state_q == ST_RST_REC && cnt_q <= 16'h1 && ready_busy_out) nxt = ST_IDLE;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      flash_ctl     <= '{chip_sel_n: 1'b1, out_en_n: 1'b1, write_n: 1'b1, reset_n: 1'b1,
                         wide_sel: 1'b1, accel_program_pin: 1'b0};
      flash_addr    <= '0;
      flash_dq_out  <= '0;
      flash_dq_oe_n <= 1'b1;
    end else begin
      // Standby between cycles: chip select and reset held high
      flash_ctl.chip_sel_n <= !(nxt == ST_RD_WAIT || nxt == ST_WR_PULSE || nxt == ST_WR_HOLD);
      flash_ctl.out_en_n   <= !(nxt == ST_RD_WAIT);
      flash_ctl.write_n    <= !(nxt == ST_WR_PULSE);
      flash_ctl.reset_n    <= !(nxt == ST_RST_PULSE);
      flash_ctl.wide_sel   <= (cmd_go && avs_address == REG_CTRL) ? avs_writedata[CTRL_WIDE_BIT] : wide_q;
      // High voltage only while a program cycle drives the pins
      flash_ctl.accel_program_pin <= (cmd_go ? avs_writedata[CTRL_ACCEL_BIT] : accel_q) &&
                                     (nxt == ST_WR_PULSE || nxt == ST_WR_HOLD);
      flash_addr    <= addr_q;
      flash_dq_out  <= wdata_q;
      flash_dq_oe_n <= !(nxt == ST_WR_PULSE || nxt == ST_WR_HOLD);
    end
  end

endmodule

// ===== test/bfc_flash_model.sv
`timescale 1ns/1ps
module bfc_flash_model
  import bfc_pkg::*;
#(
  parameter int LAT_CYC  = 3,
  parameter int BUSY_CYC = 100
) (
  input wire logic              clock,
  input bfc_pins_s              flash_ctl,
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic [DATA_W-1:0] flash_dq_out,
  output logic     [DATA_W-1:0] flash_dq_in,
  output logic                  ready_busy_out
);
  // ----
  // Array, busy timer, output drive
  // ----
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  logic [DATA_W-1:0] last_q = '0;
  logic [DATA_W-1:0] word;
  logic [ADDR_W-1:0] pend_q = '0;
  int                busy_q = 0;
  int                rd_q = 0;
  wire drive = !flash_ctl.chip_sel_n && !flash_ctl.out_en_n && flash_ctl.reset_n;
  always @* begin
    word = mem.exists(flash_addr) ? mem[flash_addr] : 32'hffffffff;
    if (!drive || rd_q < LAT_CYC) flash_dq_in = ~last_q;
    else if (flash_ctl.wide_sel) flash_dq_in = word;
    else flash_dq_in = {~last_q[31:16], word[15:0]};
  end
  assign ready_busy_out = (busy_q == 0);
  always @(posedge clock) begin
    last_q <= flash_dq_in;
    rd_q <= drive ? rd_q + 1 : 0;
    if (!flash_ctl.reset_n) begin
      if (busy_q != 0) begin
        busy_q <= BUSY_CYC;
        mem.delete(pend_q);
      end
    end else if (!flash_ctl.write_n && !flash_ctl.chip_sel_n && flash_ctl.out_en_n) begin
      mem[flash_addr] = flash_ctl.wide_sel ? flash_dq_out : {16'h0, flash_dq_out[15:0]};
      pend_q <= flash_addr;
      busy_q <= BUSY_CYC;
    end else if (busy_q != 0) busy_q <= busy_q - 1;
  end
endmodule

// ===== test/bfc_sva.sv
`timescale 1ns/1ps
module bfc_sva
  import bfc_pkg::*;
#(
  parameter int ACC_CYC = ACCESS_CYC,
  parameter int CE_CYC  = CE_ACCESS_CYC,
  parameter int RP_CYC  = RST_PULSE_CYC
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input bfc_pins_s flash_ctl,
  input wire logic flash_dq_oe_n
);
  // ----
  // Pulse length counters
  // ----
  localparam int RD_MIN = (ACC_CYC > CE_CYC) ? ACC_CYC : CE_CYC;
  int rst_cnt_q;
  int rd_cnt_q;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) rst_cnt_q <= 0;
    else rst_cnt_q <= flash_ctl.reset_n ? 0 : rst_cnt_q + 1;
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) rd_cnt_q <= 0;
    else rd_cnt_q <= flash_ctl.out_en_n ? 0 : rd_cnt_q + 1;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
  sequence s_ack; !avs_waitrequest ##1 avs_waitrequest; endsequence
  property p_ack; s_req |=> s_ack; endproperty
  property p_ack_cause; $fell(avs_waitrequest) |-> $past(avs_read || avs_write); endproperty
  property p_cmd; !flash_ctl.write_n |-> !flash_ctl.chip_sel_n && flash_ctl.out_en_n && !flash_dq_oe_n; endproperty
  property p_rd; !flash_ctl.out_en_n |-> flash_dq_oe_n && flash_ctl.write_n && !flash_ctl.chip_sel_n; endproperty
  property p_idle; flash_ctl.chip_sel_n |-> flash_ctl.out_en_n && flash_ctl.write_n; endproperty
  property p_rd_len; $rose(flash_ctl.out_en_n) |-> rd_cnt_q >= RD_MIN; endproperty
  property p_rst_len; $rose(flash_ctl.reset_n) |-> rst_cnt_q >= RP_CYC; endproperty
  property p_rec; $rose(flash_ctl.reset_n) |-> flash_ctl.out_en_n [*2]; endproperty
  property p_accel; flash_ctl.accel_program_pin |-> !flash_dq_oe_n && !flash_ctl.chip_sel_n; endproperty
  a_ack: assert property (p_ack) else $error("no one cycle acknowledge");
  a_ack_cause: assert property (p_ack_cause) else $error("acknowledge without request");
  a_cmd: assert property (p_cmd) else $error("bad command cycle levels");
  a_rd: assert property (p_rd) else $error("bad read cycle levels");
  a_idle: assert property (p_idle) else $error("strobe while deselected");
  a_rd_len: assert property (p_rd_len) else $error("read shorter than access time");
  a_rst_len: assert property (p_rst_len) else $error("reset pulse too short");
  a_rec: assert property (p_rec) else $error("read before reset recovery");
  a_accel: assert property (p_accel) else $error("accelerate pin high outside a program cycle");
endmodule

// ===== test/testbench.sv
`timescale 1ns/1ps
module testbench;
  import bfc_pkg::*;
  logic              clock, resetn, avs_read, avs_write, avs_waitrequest, flash_dq_oe_n, ready_busy_out;
  logic [4:0]        avs_address;
  logic [31:0]       avs_writedata, avs_readdata, rd;
  bfc_pins_s         flash_ctl;
  logic [ADDR_W-1:0] flash_addr;
  logic [DATA_W-1:0] flash_dq_out, flash_dq_in;
  int                mismatches = 0;
  int                total_checks = 0;
  bfc_host #(.ACC_CYC(3), .CE_CYC(4), .WP_CYC(6), .RP_CYC(4), .RH_CYC(2)) dut (
    .clock(clock), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .flash_ctl(flash_ctl), .flash_addr(flash_addr),
    .flash_dq_out(flash_dq_out), .flash_dq_oe_n(flash_dq_oe_n), .flash_dq_in(flash_dq_in),
    .ready_busy_out(ready_busy_out));
  bfc_flash_model u_flash (.clock(clock), .flash_ctl(flash_ctl), .flash_addr(flash_addr),
    .flash_dq_out(flash_dq_out), .flash_dq_in(flash_dq_in), .ready_busy_out(ready_busy_out));
  // ----
  // Bus and check tasks
  // ----
  task automatic report_and_stop();
    if (mismatches == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wait_idle();
    do bus(1'b0, REG_STATUS, 32'h0); while (rd[ST_BUSY_BIT] !== 1'b0);
  endtask
  function automatic logic [31:0] ctl(input logic [1:0] op, input logic wide, input logic acc);
    ctl = 32'(op);
    ctl[CTRL_WIDE_BIT] = wide;
    ctl[CTRL_ACCEL_BIT] = acc;
  endfunction
  task automatic op(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [31:0] c);
    bus(1'b1, REG_ADDR, 32'(a));
    bus(1'b1, REG_WDATA, d);
    bus(1'b1, REG_CTRL, c);
    wait_idle();
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_start();
    bus(1'b0, REG_STATUS, 32'h0);
    check(rd, 32'h2);
    bus(1'b0, REG_RDATA, 32'h0);
    check(rd, 32'h0);
    bus(1'b0, 5'h14, 32'h0);
    check(rd, 32'h0);
  endtask
  task automatic t_bank();
    for (int p = 0; p < 8; p++) begin
      bus(1'b1, REG_ADDR, 32'({p[2:0], 19'h0}));
      bus(1'b0, REG_STATUS, 32'h0);
      check(32'(rd[3:2]), (p == 0) ? 32'h0 : (p < 4) ? 32'h1 : (p < 7) ? 32'h2 : 32'h3);
    end
  endtask
  task automatic t_program(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [31:0] cw,
                           input logic [31:0] cr, input logic [31:0] exp);
    bus(1'b1, REG_ADDR, 32'(a));
    bus(1'b1, REG_WDATA, d);
    bus(1'b1, REG_CTRL, cw);
    bus(1'b1, REG_ADDR, 32'h0);
    wait_idle();
    bus(1'b1, REG_CTRL, cr);
    wait_idle();
    bus(1'b0, REG_RDATA, 32'h0);
    check(rd, exp);
  endtask
  task automatic t_simul_reset();
    op(22'h000040, 32'ha5a5a5a5, ctl(OP_WRITE, 1'b1, 1'b0));
    op(22'h3c0010, 32'h0, ctl(OP_READ, 1'b1, 1'b0));
    bus(1'b0, REG_RDATA, 32'h0);
    check(rd, 32'h1234abcd);
    bus(1'b0, REG_STATUS, 32'h0);
    check(32'(rd[ST_READY_BIT]), 32'h0);
    bus(1'b1, REG_CTRL, ctl(OP_RESET, 1'b0, 1'b0));
    wait_idle();
    check(32'(rd[3:0]), 32'he);
    op(22'h000040, 32'h0, ctl(OP_READ, 1'b1, 1'b0));
    bus(1'b0, REG_RDATA, 32'h0);
    check(rd, 32'hffffffff);
    op(22'h000040, 32'ha5a5a5a5, ctl(OP_WRITE, 1'b1, 1'b0));
    op(22'h000040, 32'h0, ctl(OP_READ, 1'b1, 1'b0));
    bus(1'b0, REG_RDATA, 32'h0);
    check(rd, 32'ha5a5a5a5);
  endtask
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    resetn = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h0;
    avs_writedata = 32'h0;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    t_start();
    t_bank();
    t_program(22'h3c0010, 32'h1234abcd, ctl(OP_WRITE, 1'b1, 1'b1), ctl(OP_READ, 1'b1, 1'b0), 32'h1234abcd);
    t_program(22'h100020, 32'h5555beef, ctl(OP_WRITE, 1'b0, 1'b0), ctl(OP_READ, 1'b0, 1'b0), 32'hbeef);
    t_simul_reset();
    report_and_stop();
  end
  initial begin
    #50000;
    mismatches++;
    report_and_stop();
  end
endmodule
bind bfc_host bfc_sva #(.ACC_CYC(ACC_CYC), .CE_CYC(CE_CYC), .RP_CYC(RP_CYC)) u_sva (
  .clock(clock), .resetn(resetn), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .flash_ctl(flash_ctl), .flash_dq_oe_n(flash_dq_oe_n));
